// ### hw/main_clock_control.sv
// Main clock control: RC trim, PLL sequencing, source choice, slow mode
`timescale 1ns/1ns
`include "clk_ctrl_regs.svh"

// Notes on behaviour
// - Any reset returns the trim register to FFh; software reloads it.
// - Calibration is trim register bits plus control/status bits 6 and 5.
// - Factory trim pairs: 5 V at first two bytes, 3.3 V next two.
// - Factory trim bytes are read-only and cannot be rewritten.
// - Stored low trim bits sit at positions 6 and 5.
// - 38-pulse programming entry forces the RC oscillator as source.
// - Factory trim bytes survive removal of read-out protection.
// - PLL multiplies 1 MHz by 4 or 8; two option bits control it.
// - PLL off and RC on: RC output is the oscillator clock.
// - PLL off and RC off: external clock is the oscillator clock.
// - After reset or wake the PLL withholds its clock until startup.
// - Lock flag sets when PLL reaches frequency; accuracy follows later.
// - Bit 1 drives the main clock onto its pin; clear frees the pin.
// - Bit 0 selects CPU clock of oscillator or oscillator divided by 32.
// - Trim register holds trim bits 9 to 2, resets to all ones.
// - Trim zero gives highest frequency, all ones the lowest.
module main_clock_control (
  // Clock and reset
  input  wire logic             mclk_in,
  input  wire logic             reset_n_in,
  // Register port
  input  wire logic [7:0]       addr_in,
  input  wire logic [7:0]       wdata_in,
  input  wire logic             wr_in,
  input  wire logic             rd_in,
  output logic      [7:0]       rdata_out,
  // Option bits and mode inputs
  input  wire logic             opt_rc_en_in,
  input  wire logic             opt_pll_en_in,
  input  wire logic             opt_pll_x8_in,
  input  wire logic             icc_38_pulse_in,
  input  wire logic             halt_wake_in,
  // Clock outputs
  output clk_ctrl_pkg::osc_src_e osc_src_out,
  output logic      [3:0]       pll_factor_out,
  output logic                  osc_clk_en_out,
  output logic                  cpu_clk_en_out,
  output logic      [9:0]       rc_trim_value_out,
  output logic      [9:0]       rc_freq_code_out,
  // Clock output pin and interrupt
  output logic                  clkout_pin_out,
  output logic                  clkout_pin_oe_n_out,
  output logic                  irq_out
);
  import clk_ctrl_pkg::*;

  logic [1:0]  main_ctrl_q;
  logic [7:0]  rc_trim_q;
  logic [1:0]  trim_lo_q;
  logic [1:0]  irq_stat_q;
  logic [1:0]  irq_mask_q;
  logic [7:0]  rdata_q;
  logic        icc_s1_q;
  logic        icc_s2_q;
  logic        icc_s3_q;
  logic        icc_q;
  pll_state_e  pll_q;
  osc_src_e    osc_src_q;
  logic [3:0]  factor_q;
  logic [4:0]  div_q;
  logic        slow_act_q;
  logic        cpu_en_q;
  logic        clkout_q;
  logic        oe_n_q;
  logic        first_q;
  logic        pll_sel;
  logic        osc_en;
  logic        cpu_en_d;
  logic        lock_evt;
  logic        stab_evt;
  logic        pll_pll_in_lock_flag;
  logic [1:0]  irq_set;
  logic [7:0]  rd_mux;

  delay_if startup_if ();
  delay_if stab_if ();

  ////////////////////////////////////////////////////////////////////////
  // Programming-mode pin: three stages, accepted once stages two and three
  // agree, so a single noisy sample never flips the clock source
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      icc_s1_q <= 1'b0;
      icc_s2_q <= 1'b0;
      icc_s3_q <= 1'b0;
      icc_q    <= 1'b0;
    end
    else
    begin
      icc_s1_q <= icc_38_pulse_in;
      icc_s2_q <= icc_s1_q;
      icc_s3_q <= icc_s2_q;
      if (icc_s2_q == icc_s3_q)
        icc_q <= icc_s3_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Software registers
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      main_ctrl_q <= 2'(`MAIN_CTRL_RST);
      rc_trim_q   <= `RC_TRIM_RST;
      trim_lo_q   <= `TRIM_LO_RST;
      irq_mask_q  <= `IRQ_RST;
    end
    else if (wr_in)
    begin
      unique case (addr_in)
        `MAIN_CTRL_ADDR: main_ctrl_q <= wdata_in[1:0];
        `RC_TRIM_ADDR:   rc_trim_q   <= wdata_in;
        `SI_CTRL_ADDR:
          trim_lo_q <= wdata_in[`TRIM_LO_MSB:`TRIM_LO_LSB];
        `IRQ_MASK_ADDR:  irq_mask_q  <= wdata_in[1:0];
        // Factory bytes have no write path at all
        default:         ;
      endcase
    end
  end

  // Full 10-bit trim; the analog cell runs faster for smaller codes
  assign rc_trim_value_out = {rc_trim_q, trim_lo_q};
  assign rc_freq_code_out  = ~rc_trim_value_out;

  ////////////////////////////////////////////////////////////////////////
  // Read mux; factory bytes are constants, so no erase can reach them
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (addr_in)
      `MAIN_CTRL_ADDR:   rd_mux = {6'h00, main_ctrl_q};
      `RC_TRIM_ADDR:     rd_mux = rc_trim_q;
      `SI_CTRL_ADDR:     rd_mux = {1'b0, trim_lo_q, 4'h0, pll_pll_in_lock_flag};
      `IRQ_STATUS_ADDR:  rd_mux = {6'h00, irq_stat_q};
      `IRQ_MASK_ADDR:    rd_mux = {6'h00, irq_mask_q};
      `FACT_HI_5V_ADDR:  rd_mux = `FACT_HI_5V_VAL;
      `FACT_LO_5V_ADDR:  rd_mux = `FACT_LO_5V_VAL;
      `FACT_HI_3V3_ADDR: rd_mux = `FACT_HI_3V3_VAL;
      `FACT_LO_3V3_ADDR: rd_mux = `FACT_LO_3V3_VAL;
      default:           rd_mux = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      rdata_q <= 8'h00;
    else if (rd_in)
      rdata_q <= rd_mux;
    else
      rdata_q <= 8'h00;
  end

  assign rdata_out = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // PLL sequencing; programming mode bypasses the PLL entirely
  assign pll_sel    = opt_pll_en_in && !icc_q;
  assign pll_pll_in_lock_flag = (pll_q == PLL_PLL_IN_LOCK_FLAG) || (pll_q == PLL_STABLE);
  // Startup timer is held cleared while off and restarted by a wake
  assign startup_if.start = (pll_q == PLL_OFF) || halt_wake_in;
  assign stab_if.start    = !pll_pll_in_lock_flag || halt_wake_in;
  assign lock_evt = (pll_q == PLL_START) && startup_if.done
                    && !halt_wake_in && pll_sel;
  assign stab_evt = (pll_q == PLL_PLL_IN_LOCK_FLAG) && stab_if.done
                    && !halt_wake_in && pll_sel;

  delay_timer #(.LIMIT(`PLL_STARTUP_CYC)) u_startup (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .tmr        (startup_if)
  );

  delay_timer #(.LIMIT(`PLL_STAB_CYC)) u_stab (
    .mclk_in    (mclk_in),
    .reset_n_in (reset_n_in),
    .tmr        (stab_if)
  );

  // Reset lands in OFF, so every reset passes through a full startup
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      pll_q <= PLL_OFF;
    else if (!pll_sel)
      pll_q <= PLL_OFF;
    else if (halt_wake_in)
      pll_q <= PLL_START;
    else
    begin
      unique case (pll_q)
        PLL_OFF:    pll_q <= PLL_START;
        PLL_START:  if (lock_evt) pll_q <= PLL_PLL_IN_LOCK_FLAG;
        PLL_PLL_IN_LOCK_FLAG: if (stab_evt) pll_q <= PLL_STABLE;
        PLL_STABLE: pll_q <= PLL_STABLE;
        default:    pll_q <= PLL_OFF;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Source and factor; PLL input is the RC when present, else external
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      osc_src_q <= OSC_RC;
      factor_q  <= 4'h0;
    end
    else if (icc_q)
    begin
      osc_src_q <= OSC_RC;
      factor_q  <= 4'h0;
    end
    else if (pll_sel)
    begin
      osc_src_q <= opt_rc_en_in ? OSC_PLL_RC : OSC_PLL_EXT;
      factor_q  <= opt_pll_x8_in ? 4'h8 : 4'h4;
    end
    else
    begin
      osc_src_q <= opt_rc_en_in ? OSC_RC : OSC_EXT;
      factor_q  <= 4'h0;
    end
  end

  assign osc_src_out    = osc_src_q;
  assign pll_factor_out = factor_q;
  // Oscillator ticks are withheld until the PLL has started
  assign osc_en         = !pll_sel || pll_pll_in_lock_flag;
  assign osc_clk_en_out = osc_en;

  ////////////////////////////////////////////////////////////////////////
  // Slow-mode divider. The mode changes only on the divider's last count,
  // so a change never shortens a period; the cost is up to 32 ticks delay
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      div_q      <= 5'h00;
      slow_act_q <= 1'b0;
    end
    else if (osc_en)
    begin
      div_q <= div_q + 5'h01;
      if (div_q == `SLOW_DIV_LAST)
        slow_act_q <= main_ctrl_q[`SLOW_BIT];
    end
  end

  assign cpu_en_d = osc_en
                    && (!slow_act_q || div_q == `SLOW_DIV_LAST);

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      cpu_en_q <= 1'b0;
    else
      cpu_en_q <= cpu_en_d;
  end

  assign cpu_clk_en_out = cpu_en_q;

  ////////////////////////////////////////////////////////////////////////
  // Clock output pin: half-rate square of the oscillator ticks
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      clkout_q <= 1'b0;
      oe_n_q   <= 1'b1;
    end
    else
    begin
      oe_n_q <= !main_ctrl_q[`CLKOUT_BIT];
      if (!main_ctrl_q[`CLKOUT_BIT])
        clkout_q <= 1'b0;
      else if (osc_en)
        clkout_q <= !clkout_q;
    end
  end

  assign clkout_pin_out      = clkout_q;
  assign clkout_pin_oe_n_out = oe_n_q;

  ////////////////////////////////////////////////////////////////////////
  // Sticky events, write one to clear; a new event beats the clear
  assign irq_set = {stab_evt, lock_evt};

  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      irq_stat_q <= `IRQ_RST;
    else if (wr_in && addr_in == `IRQ_STATUS_ADDR)
      irq_stat_q <= (irq_stat_q & ~wdata_in[1:0]) | irq_set;
    else
      irq_stat_q <= irq_stat_q | irq_set;
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  ////////////////////////////////////////////////////////////////////////
  // Checks
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
      first_q <= 1'b1;
    else
      first_q <= 1'b0;
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!reset_n_in);

  property p_trim_reset;
    first_q |-> rc_trim_q == 8'hFF && main_ctrl_q == 2'h0;
  endproperty
  a_trim_reset: assert property (p_trim_reset)
    else $error("trim or control not at reset value");

  property p_trim_low;
    wr_in && addr_in == `SI_CTRL_ADDR
      |=> rc_trim_value_out[1:0] == $past(wdata_in[6:5]);
  endproperty
  a_trim_low: assert property (p_trim_low)
    else $error("low trim bits not taken from bits 6 and 5");

  property p_trim_hold;
    !(wr_in && addr_in == `RC_TRIM_ADDR) |=> $stable(rc_trim_q);
  endproperty
  a_trim_hold: assert property (p_trim_hold)
    else $error("trim register changed without a write");

  property p_factory;
    rd_in && addr_in == `FACT_LO_5V_ADDR |=> rdata_out == 8'h40;
  endproperty
  a_factory: assert property (p_factory)
    else $error("factory low byte changed");

  property p_icc_rc;
    icc_q |=> osc_src_q == OSC_RC && pll_factor_out == 4'h0;
  endproperty
  a_icc_rc: assert property (p_icc_rc)
    else $error("programming mode did not force RC source");

  // Programming mode may drop the PLL mid-window; ticks then run from RC
  property p_startup_gap;
    pll_sel && halt_wake_in |=> (!pll_sel || !osc_en) [*8];
  endproperty
  a_startup_gap: assert property (p_startup_gap)
    else $error("PLL clock released too early after wake");

  property p_lock;
    $rose(pll_pll_in_lock_flag) |-> $past(pll_q) == PLL_START
                          && $past(startup_if.done);
  endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag set before startup delay");

  property p_slow;
    slow_act_q && div_q != 5'h1F |-> !cpu_en_d;
  endproperty
  a_slow: assert property (p_slow)
    else $error("CPU tick inside slow period");

  property p_switch;
    $changed(slow_act_q) |-> $past(div_q) == 5'h1F;
  endproperty
  a_switch: assert property (p_switch)
    else $error("slow mode switched mid period");

  property p_pin_free;
    !main_ctrl_q[`CLKOUT_BIT] |=> clkout_pin_oe_n_out && !clkout_pin_out;
  endproperty
  a_pin_free: assert property (p_pin_free)
    else $error("clock pin driven while disabled");

  property p_freq_code;
    rc_freq_code_out == ~{rc_trim_q, trim_lo_q};
  endproperty
  a_freq_code: assert property (p_freq_code)
    else $error("frequency code not monotonic in trim");

  c_lock: cover property (lock_evt);
  c_stab: cover property (stab_evt);
  c_slow: cover property ($rose(slow_act_q));
  c_icc:  cover property ($rose(icc_q));
endmodule

// ### include/clk_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CLK_CTRL_REGS_SVH
`define CLK_CTRL_REGS_SVH
`define MAIN_CTRL_ADDR    8'h00
`define RC_TRIM_ADDR      8'h01
`define SI_CTRL_ADDR      8'h02
`define IRQ_STATUS_ADDR   8'h03
`define IRQ_MASK_ADDR     8'h04
`define FACT_HI_5V_ADDR   8'h10
`define FACT_LO_5V_ADDR   8'h11
`define FACT_HI_3V3_ADDR  8'h12
`define FACT_LO_3V3_ADDR  8'h13
`define SLOW_BIT          0
`define CLKOUT_BIT        1
`define LOCK_BIT          0
`define TRIM_LO_MSB       6
`define TRIM_LO_LSB       5
`define IRQ_LOCK_BIT      0
`define IRQ_STAB_BIT      1
`define MAIN_CTRL_RST     8'h00
`define RC_TRIM_RST       8'hFF
`define TRIM_LO_RST       2'h3
`define IRQ_RST           2'h0
`define FACT_HI_5V_VAL    8'h80
`define FACT_LO_5V_VAL    8'h40
`define FACT_HI_3V3_VAL   8'h7F
`define FACT_LO_3V3_VAL   8'h20
`define SLOW_DIV_LAST     5'h1F
`define CLK_PERIOD_NS     10
`define PLL_STARTUP_NS    10000
`define PLL_STAB_NS       30000
`define PLL_STARTUP_CYC   ((`PLL_STARTUP_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`define PLL_STAB_CYC      ((`PLL_STAB_NS+`CLK_PERIOD_NS-1)/`CLK_PERIOD_NS)
`endif

// ### include/clk_ctrl_pkg.sv
// Types shared by the clock control block
package clk_ctrl_pkg;
  typedef enum logic [3:0] {
    OSC_RC      = 4'b0001,
    OSC_EXT     = 4'b0010,
    OSC_PLL_RC  = 4'b0100,
    OSC_PLL_EXT = 4'b1000
  } osc_src_e;
  typedef enum logic [3:0] {
    PLL_OFF    = 4'b0001,
    PLL_START  = 4'b0010,
    PLL_PLL_IN_LOCK_FLAG = 4'b0100,
    PLL_STABLE = 4'b1000
  } pll_state_e;
endpackage

// ### include/delay_if.sv
// Start and done handshake between the controller and a delay timer
`timescale 1ns/1ns
interface delay_if;
  logic start;
  logic done;
  modport ctrl (output start, input done);
  modport tmr (input start, output done);
endinterface

// ### hw/delay_timer.sv
// Restartable delay timer: done rises LIMIT cycles after start drops
`timescale 1ns/1ns
module delay_timer #(
  parameter int unsigned LIMIT = 1
) (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic reset_n_in,
  // Handshake
  delay_if.tmr      tmr
);
  localparam int unsigned W = $clog2(LIMIT + 1);
  localparam logic [W-1:0] LAST = W'(LIMIT - 1);

  logic [W-1:0] cnt_q;
  logic         busy_q;
  logic         done_q;

  ////////////////////////////////////////////////////////////////////////
  // Start held high keeps the count cleared, so a level acts as a hold
  always_ff @(posedge mclk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (tmr.start)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else if (busy_q)
    begin
      if (cnt_q == LAST)
      begin
        busy_q <= 1'b0;
        done_q <= 1'b1;
      end
      else
      begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign tmr.done = done_q;
endmodule

// ### dv/tb_top.sv
// Self-checking testbench for the main clock control block
`timescale 1ns/1ns
`include "clk_ctrl_regs.svh"

module tb_top;
  import clk_ctrl_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Stimulus and observed signals
  logic       mclk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic [7:0] wdata_in = 8'h00;
  logic       wr_in = 1'b0;
  logic       rd_in = 1'b0;
  logic       opt_rc_en_in = 1'b1;
  logic       opt_pll_en_in = 1'b0;
  logic       opt_pll_x8_in = 1'b0;
  logic       icc_38_pulse_in = 1'b0;
  logic       halt_wake_in = 1'b0;
  logic [7:0] rdata_out;
  osc_src_e   osc_src_out;
  logic [3:0] pll_factor_out;
  logic       osc_clk_en_out;
  logic       cpu_clk_en_out;
  logic [9:0] rc_trim_value_out;
  logic [9:0] rc_freq_code_out;
  logic       clkout_pin_out;
  logic       clkout_pin_oe_n_out;
  logic       irq_out;
  int         fail_count = 0;
  int         checks_done = 0;
  int         cycles = 0;

  // 100 MHz clock
  always #5 mclk_in = ~mclk_in;

  main_clock_control i_dut (
    .mclk_in             (mclk_in),
    .reset_n_in          (reset_n_in),
    .addr_in             (addr_in),
    .wdata_in            (wdata_in),
    .wr_in               (wr_in),
    .rd_in               (rd_in),
    .rdata_out           (rdata_out),
    .opt_rc_en_in        (opt_rc_en_in),
    .opt_pll_en_in       (opt_pll_en_in),
    .opt_pll_x8_in       (opt_pll_x8_in),
    .icc_38_pulse_in     (icc_38_pulse_in),
    .halt_wake_in        (halt_wake_in),
    .osc_src_out         (osc_src_out),
    .pll_factor_out      (pll_factor_out),
    .osc_clk_en_out      (osc_clk_en_out),
    .cpu_clk_en_out      (cpu_clk_en_out),
    .rc_trim_value_out   (rc_trim_value_out),
    .rc_freq_code_out    (rc_freq_code_out),
    .clkout_pin_out      (clkout_pin_out),
    .clkout_pin_oe_n_out (clkout_pin_oe_n_out),
    .irq_out             (irq_out)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Verdict, comparisons and bus cycles
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_val(input logic [9:0] got, input logic [9:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  task automatic do_reset(input logic rc, input logic pll, input logic x8);
    @(posedge mclk_in);
    reset_n_in <= 1'b0;
    opt_rc_en_in <= rc;
    opt_pll_en_in <= pll;
    opt_pll_x8_in <= x8;
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
  endtask

  // Hang guard: the whole run needs about 5000 cycles
  always @(posedge mclk_in)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      close_out();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset_values;
    logic [7:0] d;
    bus_wr(`RC_TRIM_ADDR, 8'h12);
    do_reset(1'b1, 1'b0, 1'b0);
    bus_rd(`MAIN_CTRL_ADDR, d);
    chk_reg(d, 8'h00);
    bus_rd(`RC_TRIM_ADDR, d);
    chk_reg(d, 8'hFF);
    bus_rd(`SI_CTRL_ADDR, d);
    chk_reg(d, 8'h60);
    bus_rd(`IRQ_MASK_ADDR, d);
    chk_reg(d, 8'h00);
    bus_rd(8'h20, d);
    chk_reg(d, 8'h00);
    chk_val(rc_trim_value_out, 10'h3FF);
    chk_val(rc_freq_code_out, 10'h000);
  endtask

  task automatic t_trim;
    logic [7:0] d;
    bus_wr(`RC_TRIM_ADDR, 8'hA5);
    bus_wr(`SI_CTRL_ADDR, 8'h20);
    bus_rd(`RC_TRIM_ADDR, d);
    chk_reg(d, 8'hA5);
    chk_val(rc_trim_value_out, {8'hA5, 2'h1});
    chk_val(rc_freq_code_out, ~{8'hA5, 2'h1});
    bus_wr(`RC_TRIM_ADDR, 8'h00);
    bus_wr(`SI_CTRL_ADDR, 8'h00);
    #1 chk_val(rc_freq_code_out, 10'h3FF);
  endtask

  task automatic t_factory;
    logic [7:0] d;
    logic [7:0] addrs [4];
    logic [7:0] vals [4];
    addrs = '{`FACT_HI_5V_ADDR, `FACT_LO_5V_ADDR,
              `FACT_HI_3V3_ADDR, `FACT_LO_3V3_ADDR};
    vals = '{`FACT_HI_5V_VAL, `FACT_LO_5V_VAL,
             `FACT_HI_3V3_VAL, `FACT_LO_3V3_VAL};
    for (int i = 0; i < 4; i++)
    begin
      bus_wr(addrs[i], 8'h0F);
      bus_rd(addrs[i], d);
      chk_reg(d, vals[i]);
      if (i % 2 == 1)
        chk_reg(d & 8'h9F, 8'h00);
    end
    bus_wr(8'h20, 8'h55);
    do_reset(1'b1, 1'b0, 1'b0);
    bus_rd(`FACT_LO_3V3_ADDR, d);
    chk_reg(d, `FACT_LO_3V3_VAL);
    bus_rd(`FACT_HI_5V_ADDR, d);
    chk_reg(d, `FACT_HI_5V_VAL);
  endtask

  task automatic t_clkout;
    logic [7:0] d;
    logic       p0;
    bus_wr(`MAIN_CTRL_ADDR, 8'hFE);
    bus_rd(`MAIN_CTRL_ADDR, d);
    chk_reg(d, 8'h02);
    @(negedge mclk_in);
    chk_val(clkout_pin_oe_n_out, 1'b0);
    p0 = clkout_pin_out;
    @(negedge mclk_in);
    // Logical not keeps the expected value one bit wide before widening
    chk_val(clkout_pin_out, !p0);
    bus_wr(`MAIN_CTRL_ADDR, 8'h00);
    repeat (2) @(negedge mclk_in);
    chk_val(clkout_pin_oe_n_out, 1'b1);
    chk_val(clkout_pin_out, 1'b0);
  endtask

  // Tick count over 320 cycles shows the divide by 32
  task automatic t_slow;
    int n;
    for (int m = 0; m < 2; m++)
    begin
      bus_wr(`MAIN_CTRL_ADDR, m[7:0]);
      repeat (40) @(posedge mclk_in);
      n = 0;
      repeat (320)
      begin
        @(negedge mclk_in);
        if (cpu_clk_en_out === 1'b1)
          n++;
      end
      chk_val(n[9:0], m ? 10'd10 : 10'd320);
    end
    bus_wr(`MAIN_CTRL_ADDR, 8'h00);
  endtask

  task automatic t_sources;
    logic [2:0] opt [4];
    osc_src_e   src [4];
    logic [3:0] fac [4];
    opt = '{3'b100, 3'b000, 3'b110, 3'b011};
    src = '{OSC_RC, OSC_EXT, OSC_PLL_RC, OSC_PLL_EXT};
    fac = '{4'd0, 4'd0, 4'd4, 4'd8};
    for (int i = 0; i < 4; i++)
    begin
      do_reset(opt[i][2], opt[i][1], opt[i][0]);
      repeat (3) @(negedge mclk_in);
      chk_val(osc_src_out, src[i]);
      chk_val(pll_factor_out, fac[i]);
    end
  endtask

  // Lock timing, interrupt raise, clear and mask, stable event, wake
  task automatic t_pll;
    logic [7:0] d;
    int         start;
    int         k;
    do_reset(1'b1, 1'b1, 1'b1);
    start = cycles;
    repeat (500) @(posedge mclk_in);
    #1 chk_val(osc_clk_en_out, 1'b0);
    d = 8'h00;
    k = 0;
    while (d[`LOCK_BIT] !== 1'b1 && k < 400)
    begin
      bus_rd(`SI_CTRL_ADDR, d);
      k++;
    end
    chk_val(cycles - start >= 995 && cycles - start <= 1010, 1'b1);
    chk_val(osc_clk_en_out, 1'b1);
    chk_val(irq_out, 1'b0);
    bus_wr(`IRQ_MASK_ADDR, 8'h01);
    #1 chk_val(irq_out, 1'b1);
    bus_wr(`IRQ_STATUS_ADDR, 8'h01);
    #1 chk_val(irq_out, 1'b0);
    bus_rd(`SI_CTRL_ADDR, d);
    chk_reg(d[0], 1'b1);
    k = 0;
    d = 8'h00;
    while (d[`IRQ_STAB_BIT] !== 1'b1 && k < 1600)
    begin
      bus_rd(`IRQ_STATUS_ADDR, d);
      k++;
    end
    chk_reg(d, 8'h02);
    chk_val(irq_out, 1'b0);
    bus_wr(`IRQ_MASK_ADDR, 8'h02);
    #1 chk_val(irq_out, 1'b1);
    @(posedge mclk_in);
    halt_wake_in <= 1'b1;
    @(posedge mclk_in);
    halt_wake_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    #1 chk_val(osc_clk_en_out, 1'b0);
    bus_rd(`SI_CTRL_ADDR, d);
    chk_reg(d[0], 1'b0);
  endtask

  task automatic t_icc;
    @(posedge mclk_in);
    icc_38_pulse_in <= 1'b1;
    repeat (6) @(negedge mclk_in);
    chk_val(osc_src_out, OSC_RC);
    chk_val(pll_factor_out, 4'd0);
    @(posedge mclk_in);
    icc_38_pulse_in <= 1'b0;
    // Part without RC: options off, 38-pulse pin idle, bench gives clock
    do_reset(1'b0, 1'b0, 1'b0);
    repeat (3) @(negedge mclk_in);
    chk_val(osc_src_out, OSC_EXT);
    chk_val(pll_factor_out, 4'd0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk_in);
    reset_n_in <= 1'b1;
    t_reset_values();
    t_trim();
    t_factory();
    t_clkout();
    t_slow();
    t_sources();
    t_pll();
    t_icc();
    close_out();
  end
endmodule
